/* File: logic/tlic_pkg.sv */
// Purpose: Shared constants of the top-level interrupt controller.
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz system clock.
// Notes: Offsets are byte addresses on the register bus.
`default_nettype none
package tlic_pkg;
  // Register byte addresses
  localparam logic [31:0] ENABLE_SET_ADDR = 32'he000e100;
  localparam logic [31:0] ENABLE_CLEAR_ADDR = 32'he000e180;
  localparam logic [31:0] PENDING_SET_ADDR = 32'he000e200;
  localparam logic [31:0] AUX_FAULT_ADDR = 32'he000e400;
  localparam logic [31:0] EVT_STATUS_ADDR = 32'he000e404;
  localparam logic [31:0] EVT_MASK_ADDR = 32'he000e408;
  localparam logic [31:0] WDOG_CTRL_ADDR = 32'he000e40c;
  localparam logic [31:0] CLK_STATUS_ADDR = 32'he000e410;
  // Top-level lines: 16 debug, 15 D, 14 C, 12 A, 10 rx, 9 tx,
  // 8 radio timer, 7 security, 5 serial, 4 sleep, 3 baseband, 2 mgmt
  localparam int LINE_W = 17;
  localparam logic [16:0] LINE_IMPL = 17'h1d7bc;
  localparam logic [16:0] ENABLE_RST = 17'h00000;
  localparam logic [16:0] PENDING_RST = 17'h00000;
  // Aux fault status fields
  localparam int FLT_W = 4;
  localparam int FLT_WRONG_SIZE = 0;
  localparam int FLT_PROTECTED = 1;
  localparam int FLT_UNMAPPED = 2;
  localparam int FLT_SECOND = 3;
  localparam logic [3:0] FLT_RST = 4'h0;
  // Event status / mask fields
  localparam int EVT_W = 3;
  localparam int EVT_XTAL = 0;
  localparam int EVT_WDOG = 1;
  localparam int EVT_BUSF = 2;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam int WDOG_EN_BIT = 0;
  localparam int CLK_ON_RC_BIT = 0;
  // Access size codes
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam real WDOG_LOW_WATER_S = 1.792;
  localparam int unsigned WDOG_CYCLES =
    int'(WDOG_LOW_WATER_S * 1.0e9 / CLK_PERIOD_NS);
  localparam int XTAL_TIMEOUT_NS = 1000;
  localparam int XTAL_TIMEOUT_CYC =
    (XTAL_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Memory tops, above which an access is unmapped
  localparam logic [31:0] FLASH_BASE = 32'h08000000;
  localparam logic [31:0] FLASH_TOP = 32'h0802ffff;
  localparam logic [31:0] RAM_BASE = 32'h20000000;
  localparam logic [31:0] RAM_TOP = 32'h20002fff;
  localparam logic [31:0] REGION_SPAN = 32'h10000000;
endpackage : tlic_pkg
`default_nettype wire

/* File: logic/tlic_xtal_monitor.sv */
// Purpose: Crystal failure detection and fallback to the RC clock.
// Assumes: xtal_toggle changes level on every crystal cycle.
// Notes: Once on the RC clock it stays there until reset.
`timescale 1ns/1ns
`default_nettype none
module tlic_xtal_monitor
  import tlic_pkg::*;
#(
  parameter int TIMEOUT = XTAL_TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic xtal_toggle,
  input wire logic mux_on_rc,
  output logic sel_rc,
  output logic fail_event
);
  typedef enum logic [1:0] {ON_XTAL, SWITCHING, ON_RC} tlic_xstate_t;
  tlic_xstate_t state, next_state;
  logic [15:0] quiet, next_quiet;
  logic last_tog, next_sel_rc, next_fail_event;

  // Silence watch, then switch, then report once switch is done
  always_comb begin
    next_state = state;
    next_quiet = quiet;
    next_sel_rc = sel_rc;
    next_fail_event = 1'b0;
    unique case (state)
      ON_XTAL: begin
        if (xtal_toggle != last_tog) begin
          next_quiet = 16'h0000;
        end else if (quiet >= 16'(TIMEOUT - 1)) begin
          next_state = SWITCHING;
          next_sel_rc = 1'b1;
        end else begin
          next_quiet = quiet + 16'h0001;
        end
      end
      SWITCHING: begin
        // Event waits for the mux, so the NMI runs on a live clock
        if (mux_on_rc) begin
          next_state = ON_RC;
          next_fail_event = 1'b1;
        end
      end
      ON_RC: next_state = ON_RC;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ON_XTAL;
      quiet <= 16'h0000;
      last_tog <= 1'b0;
      sel_rc <= 1'b0;
      fail_event <= 1'b0;
    end else begin
      state <= next_state;
      quiet <= next_quiet;
      last_tog <= xtal_toggle;
      sel_rc <= next_sel_rc;
      fail_event <= next_fail_event;
    end
  end
endmodule : tlic_xtal_monitor
`default_nettype wire

/* File: logic/tlic_watchdog.sv */
// Purpose: Watchdog low-water detection.
// Assumes: refresh is a one-cycle pulse from a register write.
// Notes: Raises one pulse per unrefreshed period, then holds.
`timescale 1ns/1ns
`default_nettype none
module tlic_watchdog
  import tlic_pkg::*;
#(
  parameter int unsigned LIMIT = WDOG_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic refresh,
  output logic low_water
);
  logic [31:0] count, next_count;
  logic next_low_water;

  // Count only while active; disabling or refreshing restarts
  always_comb begin
    next_count = count;
    next_low_water = 1'b0;
    if (!enable || refresh) begin
      next_count = 32'h00000000;
    end else if (count == LIMIT - 1) begin
      next_count = LIMIT;
      next_low_water = 1'b1;
    end else if (count < LIMIT) begin
      next_count = count + 32'h00000001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 32'h00000000;
      low_water <= 1'b0;
    end else begin
      count <= next_count;
      low_water <= next_low_water;
    end
  end
endmodule : tlic_watchdog
`default_nettype wire

/* File: logic/tlic_top.sv */
// Purpose: Top-level interrupt enables, NMI sourcing, bus faults.
// Assumes: All inputs synchronous to aclk; AXI4-Lite slave.
// Notes: Unmapped register addresses answer SLVERR.
// Functional notes
// - The NMI comes only from crystal failure and watchdog low water.
// - A stopped crystal is detected and the clock moved to the RC.
// - Crystal failure is reported only after the switch has finished.
// - An active, unrefreshed watchdog raises its event after 1.792 s.
// - Each bus fault cause has its own bit; several may set at once.
// - 8/16-bit peripheral accesses and unaligned words are wrong size.
// - User writes to system peripherals or protected RAM are faults.
// - Holes above peripheral registers or memory tops are unmapped.
// - A fault while another is logged sets the second-fault bit.
// - Writing ones to enable-set enables lines; zeros do nothing.
// - Writing ones to enable-clear disables lines; zeros do nothing.
// - Lines 16,15,14,12,10,9,8,7,5,4,3,2 exist; the rest reserved.
// - All enables are clear after reset.
// - Writing ones to pend-set marks lines pending; zeros do nothing.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module tlic_top
  import tlic_pkg::*;
#(
  parameter int unsigned WDOG_LIMIT = WDOG_CYCLES,
  parameter int XTAL_TIMEOUT = XTAL_TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [16:0] line_req,
  input wire logic [16:0] pend_ack,
  output logic [16:0] irq_enable,
  output logic [16:0] irq_pending,
  input wire logic xtal_toggle,
  input wire logic clk_mux_on_rc,
  output logic clk_sel_rc,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic [1:0] acc_size,
  input wire logic acc_write,
  input wire logic acc_user,
  input wire logic acc_periph,
  input wire logic acc_system,
  input wire logic acc_prot_ram,
  input wire logic acc_hole,
  output logic bus_fault,
  output logic nmi,
  output logic irq
);
  // Write channel state
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [31:0] aw_addr, w_data, next_aw_addr, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid;
  logic [1:0] next_bresp;
  logic wr_fire;
  // Read channel state
  logic next_arready, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic rd_fire;
  // Register state
  logic [16:0] next_enable, next_pending;
  logic [3:0] aux_fault, next_aux_fault;
  logic [2:0] evt_status, next_evt_status;
  logic [2:0] evt_mask, next_evt_mask;
  logic wdog_en, next_wdog_en;
  logic next_nmi, next_irq, next_bus_fault;
  logic [31:0] wmask, wbits;
  logic [3:0] flt_now;
  logic wdog_refresh, xtal_fail, wdog_low;
  logic mem_hi;

  tlic_xtal_monitor #(.TIMEOUT(XTAL_TIMEOUT)) u_xtal (
    .aclk(aclk),
    .aresetn(aresetn),
    .xtal_toggle(xtal_toggle),
    .mux_on_rc(clk_mux_on_rc),
    .sel_rc(clk_sel_rc),
    .fail_event(xtal_fail)
  );

  tlic_watchdog #(.LIMIT(WDOG_LIMIT)) u_wdog (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(wdog_en),
    .refresh(wdog_refresh),
    .low_water(wdog_low)
  );

  // Address and data are caught separately, in either order
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    wr_fire = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      wr_fire = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      unique case (aw_addr)
        ENABLE_SET_ADDR, ENABLE_CLEAR_ADDR, PENDING_SET_ADDR,
        AUX_FAULT_ADDR, EVT_STATUS_ADDR, EVT_MASK_ADDR,
        WDOG_CTRL_ADDR, CLK_STATUS_ADDR: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // Read answers one cycle after the address is taken
  always_comb begin
    rd_fire = s_axi_arvalid && s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h00000000;
      unique case (s_axi_araddr)
        ENABLE_SET_ADDR, ENABLE_CLEAR_ADDR:
          next_rdata = {15'h0000, irq_enable & LINE_IMPL};
        PENDING_SET_ADDR: next_rdata = {15'h0000, irq_pending};
        AUX_FAULT_ADDR: next_rdata = {28'h0000000, aux_fault};
        EVT_STATUS_ADDR: next_rdata = {29'h00000000, evt_status};
        EVT_MASK_ADDR: next_rdata = {29'h00000000, evt_mask};
        WDOG_CTRL_ADDR: next_rdata = {31'h00000000, wdog_en};
        CLK_STATUS_ADDR: next_rdata = {31'h00000000, clk_sel_rc};
        default: next_rresp = RESP_SLVERR;
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // Bus fault causes of the current access, each checked on its own
  always_comb begin
    mem_hi = ((acc_addr > FLASH_TOP) &&
              (acc_addr < FLASH_BASE + REGION_SPAN)) ||
             ((acc_addr > RAM_TOP) &&
              (acc_addr < RAM_BASE + REGION_SPAN));
    flt_now = 4'h0;
    flt_now[FLT_WRONG_SIZE] = acc_valid &&
      ((acc_periph && (acc_size != SIZE_32)) ||
       ((acc_size == SIZE_32) && (acc_addr[1:0] != 2'h0)));
    flt_now[FLT_PROTECTED] = acc_valid && acc_write && acc_user &&
      (acc_system || acc_prot_ram);
    flt_now[FLT_UNMAPPED] = acc_valid && (acc_hole || mem_hi);
    // A fault that lands on an already logged one is a second fault
    flt_now[FLT_SECOND] = (|flt_now[2:0]) && (|aux_fault[2:0]);
  end

  // Registers; every sticky bit lets a same-cycle set beat the clear
  always_comb begin
    wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
             {8{w_strb[1]}}, {8{w_strb[0]}}};
    wbits = wr_fire ? (w_data & wmask) : 32'h00000000;
    next_enable = irq_enable;
    next_pending = (irq_pending & ~pend_ack) | (line_req & LINE_IMPL);
    next_aux_fault = aux_fault;
    next_evt_status = evt_status;
    next_evt_mask = evt_mask;
    next_wdog_en = wdog_en;
    wdog_refresh = 1'b0;
    if (aw_addr == ENABLE_SET_ADDR) begin
      next_enable = irq_enable | (wbits[16:0] & LINE_IMPL);
    end
    if (aw_addr == ENABLE_CLEAR_ADDR) begin
      next_enable = irq_enable & ~wbits[16:0];
    end
    if (aw_addr == PENDING_SET_ADDR) begin
      next_pending = next_pending | (wbits[16:0] & LINE_IMPL);
    end
    if (aw_addr == AUX_FAULT_ADDR) begin
      next_aux_fault = aux_fault & ~wbits[3:0];
    end
    if (wr_fire && (aw_addr == EVT_MASK_ADDR)) begin
      next_evt_mask = wbits[2:0];
    end
    if (wr_fire && (aw_addr == WDOG_CTRL_ADDR)) begin
      // Any write to control also restarts the count
      next_wdog_en = w_data[WDOG_EN_BIT];
      wdog_refresh = 1'b1;
    end
    if (rd_fire && (s_axi_araddr == EVT_STATUS_ADDR)) begin
      next_evt_status = 3'h0;
    end
    next_aux_fault = next_aux_fault | flt_now;
    next_evt_status[EVT_XTAL] = next_evt_status[EVT_XTAL] | xtal_fail;
    next_evt_status[EVT_WDOG] = next_evt_status[EVT_WDOG] | wdog_low;
    next_evt_status[EVT_BUSF] = next_evt_status[EVT_BUSF] | (|flt_now);
    next_bus_fault = |flt_now;
    // Only these two sources reach the NMI, and the mask is ignored
    next_nmi = next_evt_status[EVT_XTAL] ||
               next_evt_status[EVT_WDOG];
    next_irq = |(next_evt_status & next_evt_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= ENABLE_RST;
      irq_pending <= PENDING_RST;
      aux_fault <= FLT_RST;
      evt_status <= EVT_RST;
      evt_mask <= EVT_RST;
      wdog_en <= 1'b0;
      bus_fault <= 1'b0;
      nmi <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_enable <= next_enable;
      irq_pending <= next_pending;
      aux_fault <= next_aux_fault;
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      wdog_en <= next_wdog_en;
      bus_fault <= next_bus_fault;
      nmi <= next_nmi;
      irq <= next_irq;
    end
  end
endmodule : tlic_top
`default_nettype wire

/* File: tb/tlic_top_properties.sv */
// Purpose: Port-level checks of the interrupt controller top.
// Assumes: Single clock domain, synchronous active-low reset.
// Notes: Bound into tlic_top; watches design ports only.
`timescale 1ns/1ns
`default_nettype none
module tlic_top_properties
  import tlic_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [16:0] irq_enable,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic [1:0] acc_size,
  input wire logic acc_write,
  input wire logic acc_user,
  input wire logic acc_periph,
  input wire logic acc_system,
  input wire logic acc_prot_ram,
  input wire logic acc_hole,
  input wire logic bus_fault,
  input wire logic xtal_toggle,
  input wire logic clk_mux_on_rc,
  input wire logic clk_sel_rc,
  input wire logic nmi
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Switch finished: RC requested and the mux reports it running
  sequence switch_done;
    clk_sel_rc && $rose(clk_mux_on_rc);
  endsequence
  // A live crystal must never trigger the fallback
  sequence xtal_live;
    !clk_sel_rc && !$stable(xtal_toggle);
  endsequence
  resp_stands_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_stands_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  reserved_zero_a: assert property (
    (irq_enable & ~LINE_IMPL) == 17'h0)
    else $error("reserved enable bit set");
  enable_by_write_a: assert property (
    !$stable(irq_enable) |-> $rose(s_axi_bvalid))
    else $error("enables moved without a write");
  reset_clear_a: assert property (disable iff (1'b0)
    !aresetn |=> irq_enable == 17'h0)
    else $error("enables not cleared by reset");
  narrow_fault_a: assert property (
    acc_valid && acc_periph && acc_size != SIZE_32 |=> bus_fault)
    else $error("narrow access not faulted");
  unaligned_a: assert property (
    acc_valid && acc_size == SIZE_32 && acc_addr[1:0] != 2'h0 |=> bus_fault)
    else $error("unaligned word not faulted");
  user_write_a: assert property (
    acc_valid && acc_write && acc_user && (acc_system || acc_prot_ram)
    |=> bus_fault)
    else $error("user write not faulted");
  hole_fault_a: assert property (
    acc_valid && acc_hole |=> bus_fault)
    else $error("hole access not faulted");
  no_cause_a: assert property (
    !acc_valid |=> !bus_fault)
    else $error("fault without an access");
  xtal_kept_a: assert property (
    xtal_live |=> !clk_sel_rc)
    else $error("fallback with crystal running");
  nmi_after_a: assert property (
    switch_done |-> ##[1:3] nmi)
    else $error("no nmi after clock switch");
endmodule : tlic_top_properties
bind tlic_top tlic_top_properties tlic_top_properties_inst (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq_enable, .acc_valid,
  .acc_addr, .acc_size, .acc_write, .acc_user, .acc_periph, .acc_system,
  .acc_prot_ram, .acc_hole, .bus_fault, .xtal_toggle, .clk_mux_on_rc,
  .clk_sel_rc, .nmi);
`default_nettype wire

/* File: tb/tlic_far_side.sv */
// Purpose: Crystal and clock mux standing beside the controller.
// Assumes: run high means the crystal oscillates.
// Notes: A stopped crystal holds its last level, as a dead one does.
`timescale 1ns/1ns
`default_nettype none
module tlic_far_side #(
  parameter int SLOW_DELAY = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic slow,
  input wire logic sel_rc,
  output logic xtal_toggle,
  output logic mux_on_rc
);
  int cnt;
  // Crystal edges and a mux that needs time to settle on the RC
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_toggle <= 1'b0;
      mux_on_rc <= 1'b0;
      cnt <= 0;
    end else begin
      if (run) xtal_toggle <= ~xtal_toggle;
      if (sel_rc && !mux_on_rc) begin
        cnt <= cnt + 1;
        if (cnt >= (slow ? SLOW_DELAY : 0)) mux_on_rc <= 1'b1;
      end
    end
  end
endmodule : tlic_far_side
`default_nettype wire

/* File: tb/tlic_top_tb.sv */
// Purpose: Register, fault and NMI tests of the controller top.
// Assumes: Short watchdog and crystal limits for a brief run.
// Notes: Ready lines are raised late once, so the response must stand.
`timescale 1ns/1ns
`default_nettype none
module tlic_top_tb;
  import tlic_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, run, slow;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0] acc_addr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, acc_size;
  logic [16:0] line_req, pend_ack, irq_enable, irq_pending;
  logic xtal_toggle, clk_mux_on_rc, clk_sel_rc, acc_valid, acc_write;
  logic acc_user, acc_periph, acc_system, acc_prot_ram, acc_hole;
  logic bus_fault, nmi, irq;
  int n_errors, n_checks;
  tlic_top #(.WDOG_LIMIT(50), .XTAL_TIMEOUT(4)) tlic_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .line_req, .pend_ack, .irq_enable, .irq_pending,
    .xtal_toggle, .clk_mux_on_rc, .clk_sel_rc, .acc_valid, .acc_addr,
    .acc_size, .acc_write, .acc_user, .acc_periph, .acc_system,
    .acc_prot_ram, .acc_hole, .bus_fault, .nmi, .irq);
  tlic_far_side tlic_far_side_inst (.aclk, .aresetn, .run, .slow,
    .sel_rc(clk_sel_rc), .xtal_toggle, .mux_on_rc(clk_mux_on_rc));
  // Free-running system clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic fail;
    n_errors++;
    $display("MISMATCH %0t wait ran out", $time);
    report_and_stop();
  endtask : fail
  // Waits a bounded time for irq (0), nmi (1) or clk_sel_rc (2)
  task automatic await(input int w, input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      if ((w == 0 ? irq : w == 1 ? nmi : clk_sel_rc) === v) break;
      @(posedge aclk);
    end
    n_checks++;
    if (i == n) fail();
  endtask : await
  task automatic wr(input logic [31:0] a, v, input logic [1:0] er);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    if (i == 50) fail();
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    if (i == 50) fail();
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  // One monitored access; flags are write,user,periph,system,prot,hole
  task automatic acc(input logic [1:0] sz, input logic [31:0] ad,
    input logic [5:0] f, input logic [3:0] ex, input logic cl);
    acc_size <= sz;
    acc_addr <= ad;
    {acc_write, acc_user, acc_periph, acc_system, acc_prot_ram,
      acc_hole} <= f;
    acc_valid <= 1'b1;
    @(posedge aclk);
    acc_valid <= 1'b0;
    #1;
    chk({31'h0, bus_fault}, {31'h0, |ex});
    @(posedge aclk);
    rd(AUX_FAULT_ADDR, {28'h0, ex}, RESP_OKAY);
    if (cl) wr(AUX_FAULT_ADDR, 32'hf, RESP_OKAY);
  endtask : acc
  task automatic rst;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : rst
  // Main sequence; ready lines stay high except in one late-ready pair
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, slow} = 5'h0;
    {s_axi_bready, s_axi_rready, run} = 3'h7;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, acc_addr} = 128'h0;
    s_axi_wstrb = 4'hf;
    {line_req, pend_ack} = 34'h0;
    {acc_valid, acc_write, acc_user, acc_size} = 5'h0;
    {acc_periph, acc_system, acc_prot_ram, acc_hole} = 4'h0;
    n_errors = 0;
    n_checks = 0;
    rst();
    rd(ENABLE_SET_ADDR, 32'h0, RESP_OKAY);
    rd(ENABLE_CLEAR_ADDR, 32'h0, RESP_OKAY);
    wr(ENABLE_SET_ADDR, 32'hffffffff, RESP_OKAY);
    rd(ENABLE_CLEAR_ADDR, {15'h0, LINE_IMPL}, RESP_OKAY);
    chk({15'h0, irq_enable}, {15'h0, LINE_IMPL});
    wr(ENABLE_CLEAR_ADDR, 32'h00010004, RESP_OKAY);
    wr(ENABLE_SET_ADDR, 32'h0, RESP_OKAY);
    wr(ENABLE_CLEAR_ADDR, 32'h0, RESP_OKAY);
    rd(ENABLE_SET_ADDR, {15'h0, LINE_IMPL & 17'h0fffb}, RESP_OKAY);
    // Only byte lane 2 is written, so only line 16 comes back
    s_axi_wstrb <= 4'h4;
    wr(ENABLE_SET_ADDR, 32'hffffffff, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ENABLE_SET_ADDR, {15'h0, LINE_IMPL & 17'h1fffb}, RESP_OKAY);
    wr(PENDING_SET_ADDR, 32'h00010004, RESP_OKAY);
    // Late ready: the response has to wait for the master
    {s_axi_bready, s_axi_rready} <= 2'b00;
    wr(PENDING_SET_ADDR, 32'h0, RESP_OKAY);
    rd(PENDING_SET_ADDR, 32'h00010004, RESP_OKAY);
    pend_ack <= 17'h1ffff;
    @(posedge aclk);
    pend_ack <= 17'h0;
    line_req <= 17'h00400;
    @(posedge aclk);
    line_req <= 17'h0;
    @(posedge aclk);
    chk({15'h0, irq_pending}, 32'h00400);
    rd(32'he000e3f0, 32'h0, RESP_SLVERR);
    wr(32'he000e3f0, 32'hffffffff, RESP_SLVERR);
    acc(SIZE_8, 32'h40000000, 6'b001000, 4'h1, 1'b1);
    acc(SIZE_16, 32'h40000004, 6'b101000, 4'h1, 1'b1);
    acc(SIZE_32, 32'h40000002, 6'b000000, 4'h1, 1'b1);
    acc(SIZE_32, 32'h40000000, 6'b111100, 4'h2, 1'b1);
    acc(SIZE_32, 32'h20000000, 6'b110010, 4'h2, 1'b1);
    acc(SIZE_32, 32'h20000000, 6'b010010, 4'h0, 1'b1);
    acc(SIZE_32, 32'h40000ff0, 6'b001001, 4'h4, 1'b1);
    acc(SIZE_32, 32'h20003000, 6'b000000, 4'h4, 1'b1);
    acc(SIZE_32, 32'h08030000, 6'b000000, 4'h4, 1'b1);
    acc(SIZE_8, 32'h40000ff1, 6'b001001, 4'h5, 1'b1);
    acc(SIZE_8, 32'h40000000, 6'b001000, 4'h1, 1'b0);
    acc(SIZE_32, 32'h40000ff0, 6'b001001, 4'hd, 1'b1);
    rd(EVT_MASK_ADDR, 32'h0, RESP_OKAY);
    await(0, 1'b0, 5);
    wr(EVT_MASK_ADDR, 32'h4, RESP_OKAY);
    await(0, 1'b1, 5);
    chk({31'h0, nmi}, 32'h0);
    rd(EVT_STATUS_ADDR, 32'h4, RESP_OKAY);
    await(0, 1'b0, 5);
    run <= 1'b0;
    await(2, 1'b1, 20);
    await(1, 1'b1, 20);
    rd(CLK_STATUS_ADDR, 32'h1, RESP_OKAY);
    rd(EVT_STATUS_ADDR, 32'h1, RESP_OKAY);
    await(1, 1'b0, 5);
    wr(WDOG_CTRL_ADDR, 32'h1, RESP_OKAY);
    repeat (30) @(posedge aclk);
    wr(WDOG_CTRL_ADDR, 32'h1, RESP_OKAY);
    repeat (30) @(posedge aclk);
    chk({31'h0, nmi}, 32'h0);
    await(1, 1'b1, 40);
    rd(EVT_STATUS_ADDR, 32'h2, RESP_OKAY);
    wr(WDOG_CTRL_ADDR, 32'h0, RESP_OKAY);
    run <= 1'b1;
    slow <= 1'b1;
    rst();
    rd(ENABLE_SET_ADDR, 32'h0, RESP_OKAY);
    chk({31'h0, clk_sel_rc}, 32'h0);
    run <= 1'b0;
    await(2, 1'b1, 20);
    chk({31'h0, nmi}, 32'h0);
    await(1, 1'b1, 30);
    report_and_stop();
  end
endmodule : tlic_top_tb
`default_nettype wire
